// ===== src/irq_defines.svh
// Purpose: Shared constants of the transceiver interrupt logic
// Assumes: Included by bare name in the interrupt logic and its bench
// Notes:   Offsets are word indexes on the plain register port
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// ----------------------------------------
// Register port
// ----------------------------------------
`define IRQ_ADDR_W 4
`define IRQ_DATA_W 8
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h1
`define OFS_MASK 4'h2

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_W 4
`define CTRL_SEL_LO 0
`define CTRL_SEL_HI 1
`define CTRL_T_MODE 2
`define CTRL_P_MODE 3
`define CTRL_RST 4'h0

// ----------------------------------------
// Source bits of the status register
// ----------------------------------------
`define NSRC 7
`define SRC_NPWR 0
`define SRC_PWR 1
`define SRC_TXL 2
`define SRC_RXL 3
`define SRC_RXE 4
`define SRC_BCK 5
`define SRC_FDE 6
`define MASK_RST 7'h7f
`define GRP_STATUS 7'h03
`define GRP_TX 7'h04
`define GRP_RX 7'h78

// ----------------------------------------
// Buffer fill levels
// ----------------------------------------
`define FILL_W 5
`define FILL_EMPTY 5'h00
`define THR_ONE 5'h01
`define THR_TWO 5'h02
`define THR_FOUR 5'h04
`define THR_TWELVE 5'h0c

`endif

// ===== src/irq_flag.sv
// Purpose: One sticky interrupt source flag
// Assumes: Set and clear are single-cycle terms on clk_i
// Notes:   Set wins over clear so no event is lost
module irq_flag (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic set_i,
    input wire logic clr_i,
    // State
    output logic flag_o
);

    logic flag_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flag_q <= 1'b0;
        end else if (set_i) begin
            flag_q <= 1'b1;
        end else if (clr_i) begin
            flag_q <= 1'b0;
        end
    end

    assign flag_o = flag_q;

    set_beats_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (set_i && clr_i) |=> flag_o)
        else $error("Set lost against clear");

endmodule : irq_flag

// ===== src/irq_pkg.sv
// Purpose: Types of the transceiver interrupt logic
// Assumes: Nothing
// Notes:   Used by full name, never imported
package irq_pkg;

    // ----------------------------------------
    // Threshold select encoding {hi, lo}
    // ----------------------------------------
    typedef enum logic [1:0] {
        THR_SEL_1 = 2'b00,
        THR_SEL_2 = 2'b01,
        THR_SEL_4 = 2'b10,
        THR_SEL_12 = 2'b11
    } threshold_sel_t;

endpackage : irq_pkg

// ===== src/transceiver_irq_logic.sv
// Purpose: Interrupt logic of the transceiver, one level interrupt line
// Assumes: All inputs come from logic on clk_i; host operations are one-cycle pulses
// Notes:   Interrupt output rises two cycles after the causing event
//
// Notes on behaviour
// - Any enabled condition drives the interrupt high
// - Status read never clears buffer interrupts
// - Inverse power bit interrupts on both edges
// - Power event bit interrupts on rise only
// - Status read or delete command clears power events
// - TX fill at 1,2,4,12 or empty interrupts
// - TX buffer write, control write, delete clear TX
// - RX fill at 1,2,4,12 or error interrupts
// - Successful bit-check interrupts when polling select zero
// - Two-way mode interrupts when TX buffer empties
// - No RX count or error interrupt while reading
`include "irq_defines.svh"

module transceiver_irq_logic (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [`IRQ_ADDR_W-1:0] addr_i,
    input wire logic [`IRQ_DATA_W-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [`IRQ_DATA_W-1:0] rdata_o,
    // Status bits and operating state
    input wire logic n_power_on_i,
    input wire logic power_on_i,
    input wire logic tx_active_i,
    input wire logic rx_active_i,
    input wire logic two_way_simultaneous_mode_i,
    // Buffer state and receiver events
    input wire logic [`FILL_W-1:0] tx_fill_i,
    input wire logic [`FILL_W-1:0] rx_fill_i,
    input wire logic rx_error_i,
    input wire logic bitcheck_ok_i,
    input wire logic buf_reading_i,
    // Host operations from the command interface
    input wire logic status_read_i,
    input wire logic delete_irq_i,
    input wire logic tx_buf_write_i,
    input wire logic rx_buf_read_i,
    input wire logic cfg_write_i,
    // Interrupt line
    output logic irq_o
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [`CTRL_W-1:0] ctrl_q;
    logic [`NSRC-1:0] mask_q;
    logic [`NSRC-1:0] status;
    logic [`NSRC-1:0] ev;
    logic [`NSRC-1:0] clr;
    logic [`NSRC-1:0] w1c;
    logic [`IRQ_DATA_W-1:0] rdata_q;
    logic [`FILL_W-1:0] tx_fill_q;
    logic [`FILL_W-1:0] rx_fill_q;
    logic [`FILL_W-1:0] thr;
    logic npwr_q;
    logic pwr_q;
    logic armed_q;
    logic irq_q;
    logic ctrl_wr;
    logic ctrl_any_wr;
    logic status_rd;
    logic tx_ok;
    logic rx_ok;
    irq_pkg::threshold_sel_t sel;

    // ----------------------------------------
    // Register port decode
    // ----------------------------------------
    assign ctrl_wr = we_i && (addr_i == `OFS_CTRL);
    assign ctrl_any_wr = ctrl_wr || cfg_write_i;
    assign status_rd = status_read_i || (re_i && (addr_i == `OFS_STATUS));
    assign w1c = (we_i && (addr_i == `OFS_STATUS)) ? wdata_i[`NSRC-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_q <= wdata_i[`CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mask_q <= `MASK_RST;
        end else if (we_i && (addr_i == `OFS_MASK)) begin
            mask_q <= wdata_i[`NSRC-1:0];
        end
    end

    // Unmapped reads and idle cycles return zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else if (re_i) begin
            unique case (addr_i)
                `OFS_CTRL: rdata_q <= {{(`IRQ_DATA_W-`CTRL_W){1'b0}}, ctrl_q};
                `OFS_STATUS: rdata_q <= {1'b0, status};
                `OFS_MASK: rdata_q <= {1'b0, mask_q};
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign rdata_o = rdata_q;

    // ----------------------------------------
    // Event history
    // ----------------------------------------
    // Armed one cycle after reset so a status bit high at reset is no edge
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            npwr_q <= 1'b0;
            pwr_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            npwr_q <= n_power_on_i;
            pwr_q <= power_on_i;
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_fill_q <= `FILL_EMPTY;
            rx_fill_q <= `FILL_EMPTY;
        end else begin
            tx_fill_q <= tx_fill_i;
            rx_fill_q <= rx_fill_i;
        end
    end

    // ----------------------------------------
    // Threshold select
    // ----------------------------------------
    assign sel = irq_pkg::threshold_sel_t'({ctrl_q[`CTRL_SEL_HI], ctrl_q[`CTRL_SEL_LO]});

    always_comb begin
        unique case (sel)
            irq_pkg::THR_SEL_1: thr = `THR_ONE;
            irq_pkg::THR_SEL_2: thr = `THR_TWO;
            irq_pkg::THR_SEL_4: thr = `THR_FOUR;
            irq_pkg::THR_SEL_12: thr = `THR_TWELVE;
        endcase
    end

    // ----------------------------------------
    // Event detection
    // ----------------------------------------
    assign tx_ok = tx_active_i && !ctrl_q[`CTRL_T_MODE];
    assign rx_ok = rx_active_i && !ctrl_q[`CTRL_T_MODE] && !buf_reading_i;

    always_comb begin
        ev[`SRC_NPWR] = armed_q && (n_power_on_i != npwr_q);
        ev[`SRC_PWR] = armed_q && power_on_i && !pwr_q;
        ev[`SRC_TXL] = tx_ok && (tx_fill_i != tx_fill_q) &&
            ((tx_fill_i == thr) || (tx_fill_i == `FILL_EMPTY));
        ev[`SRC_RXL] = rx_ok && (rx_fill_i != rx_fill_q) && (rx_fill_i == thr);
        ev[`SRC_RXE] = rx_ok && rx_error_i;
        ev[`SRC_BCK] = bitcheck_ok_i && !ctrl_q[`CTRL_P_MODE];
        ev[`SRC_FDE] = two_way_simultaneous_mode_i && (tx_fill_i == `FILL_EMPTY) &&
            (tx_fill_q != `FILL_EMPTY);
    end

    // ----------------------------------------
    // Clearing operations per group
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < `NSRC; i++) begin
            clr[i] = delete_irq_i || w1c[i];
        end
        // Status read clears power group only
        clr = clr | (status_rd ? `GRP_STATUS : '0);
        clr = clr | ((tx_buf_write_i || ctrl_any_wr) ? `GRP_TX : '0);
        clr = clr | ((rx_buf_read_i || ctrl_any_wr) ? `GRP_RX : '0);
    end

    // ----------------------------------------
    // Sticky status flags
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `NSRC; g++) begin : g_flag
            irq_flag u_flag (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .set_i(ev[g]),
                .clr_i(clr[g]),
                .flag_o(status[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Interrupt output
    // ----------------------------------------
    // High while any unmasked flag stands
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status & mask_q);
        end
    end

    assign irq_o = irq_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence unmasked_event_s;
        (|(ev & mask_q)) && !we_i;
    endsequence

    sequence tx_drained_s;
        two_way_simultaneous_mode_i && (tx_fill_q != `FILL_EMPTY) && (tx_fill_i == `FILL_EMPTY);
    endsequence

    irq_raise_a: assert property (
        unmasked_event_s |-> ##2 irq_o)
        else $error("Unmasked event did not raise interrupt");

    irq_hold_a: assert property (
        (|(status & mask_q)) |=> irq_o)
        else $error("Interrupt dropped with source pending");

    buf_keep_a: assert property (
        (status_rd && !delete_irq_i && (w1c == '0) && !tx_buf_write_i && !ctrl_any_wr && !rx_buf_read_i) |=>
        (($past(status) & ~status & ~(`GRP_STATUS)) == '0))
        else $error("Status read cleared a buffer interrupt");

    npwr_edge_a: assert property (
        (armed_q && $changed(n_power_on_i)) |=> status[`SRC_NPWR])
        else $error("Inverse power change missed");

    pwr_fall_a: assert property (
        (pwr_q && !power_on_i && !status[`SRC_PWR]) |=> !status[`SRC_PWR])
        else $error("Power event fall raised interrupt");

    stat_clear_a: assert property (
        (status_rd && !ev[`SRC_NPWR] && !ev[`SRC_PWR]) |=> (status[`SRC_PWR:`SRC_NPWR] == 2'h0))
        else $error("Status read did not clear power events");

    tx_level_a: assert property (
        (tx_ok && $changed(tx_fill_i) && (tx_fill_i == thr)) |=> status[`SRC_TXL])
        else $error("TX level interrupt missed");

    tx_clear_a: assert property (
        ((tx_buf_write_i || ctrl_any_wr || delete_irq_i) && !ev[`SRC_TXL]) |=> !status[`SRC_TXL])
        else $error("TX interrupt not cleared");

    rx_error_a: assert property (
        (rx_ok && rx_error_i) |=> status[`SRC_RXE])
        else $error("Receive error interrupt missed");

    rx_level_a: assert property (
        (rx_ok && $changed(rx_fill_i) && (rx_fill_i == thr)) |=> status[`SRC_RXL])
        else $error("RX level interrupt missed");

    bitchk_a: assert property (
        (bitcheck_ok_i && ctrl_q[`CTRL_P_MODE] && !status[`SRC_BCK]) |=> !status[`SRC_BCK])
        else $error("Bit-check interrupt despite polling select");

    fd_empty_a: assert property (
        tx_drained_s |=> status[`SRC_FDE] ##1 (irq_o || !$past(mask_q[`SRC_FDE])))
        else $error("Two-way empty interrupt missed");

    rx_clear_a: assert property (
        ((rx_buf_read_i || ctrl_any_wr) && (ev & `GRP_RX) == '0) |=> ((status & `GRP_RX) == '0))
        else $error("RX group not cleared");

    read_suppress_a: assert property (
        (buf_reading_i && !status[`SRC_RXE] && !status[`SRC_RXL]) |=> !status[`SRC_RXE] && !status[`SRC_RXL])
        else $error("Interrupt raised while reading buffer");

endmodule : transceiver_irq_logic

// ===== verif/mcu_model.sv
// Purpose: Host microcontroller that services the interrupt line
// Assumes: Status read is a one-cycle pulse on clk_i
// Notes:   Idle while en_i is low; DLY sets how slowly it answers
module mcu_model #(
    parameter int DLY = 3
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Interrupt side
    input wire logic en_i,
    input wire logic irq_i,
    output logic status_read_o
);
    logic [3:0] cnt_q;
    // status read after DLY+1 cycles of high line
    // Restarting the count gives the line time to fall
    always_ff @(posedge clk_i) begin
        status_read_o <= 1'b0;
        if (!rst_n_i || !en_i || !irq_i) begin
            cnt_q <= 4'h0;
        end else if (cnt_q == DLY[3:0]) begin
            cnt_q <= 4'h0;
            status_read_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : mcu_model

// ===== verif/tb_transceiver_irq_logic.sv
// Purpose: Self-checking bench of the interrupt logic
// Assumes: Two-cycle path from event to interrupt line
// Notes:   Fixed waits cover event and clear latency
`include "irq_defines.svh"
module tb_transceiver_irq_logic;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic [7:0] rdata_o;
    logic n_power_on_i = 1'b0;
    logic power_on_i = 1'b0;
    logic tx_active_i = 1'b0;
    logic rx_active_i = 1'b0;
    logic two_way_simultaneous_mode_i = 1'b0;
    logic [4:0] tx_fill_i = 5'h00;
    logic [4:0] rx_fill_i = 5'h00;
    logic buf_reading_i = 1'b0;
    logic [5:0] pls = 6'h00;
    logic status_read_i;
    logic mcu_en = 1'b0;
    logic irq_o;
    logic [4:0] thr [4] = '{5'h01, 5'h02, 5'h04, 5'h0c};
    int error_cnt = 0;
    int total_checks = 0;
    always #2.5 clk_i = ~clk_i;
    transceiver_irq_logic i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .n_power_on_i(n_power_on_i), .power_on_i(power_on_i),
        .tx_active_i(tx_active_i), .rx_active_i(rx_active_i),
        .two_way_simultaneous_mode_i(two_way_simultaneous_mode_i), .tx_fill_i(tx_fill_i),
        .rx_fill_i(rx_fill_i), .rx_error_i(pls[0]), .bitcheck_ok_i(pls[1]), .buf_reading_i(buf_reading_i),
        .status_read_i(status_read_i), .delete_irq_i(pls[2]), .tx_buf_write_i(pls[3]),
        .rx_buf_read_i(pls[4]), .cfg_write_i(pls[5]), .irq_o(irq_o));
    mcu_model #(.DLY(3)) i_mcu (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(mcu_en), .irq_i(irq_o),
        .status_read_o(status_read_i));
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd
    task automatic pulse(input int b);
        @(posedge clk_i);
        pls[b] <= 1'b1;
        @(posedge clk_i);
        pls[b] <= 1'b0;
    endtask : pulse
    task automatic irq_is(input logic e);
        repeat (3) @(posedge clk_i);
        #1;
        chk({7'h00, irq_o}, {7'h00, e});
    endtask : irq_is
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // ------------------------------
        // Reset values and unmapped index
        // ------------------------------
        rd(`OFS_CTRL, 8'h00);
        rd(`OFS_MASK, 8'h7f);
        wr(4'hf, 8'hff);
        rd(4'hf, 8'h00);
        irq_is(1'b0);
        // ------------------------------
        // Power events
        // ------------------------------
        @(posedge clk_i);
        power_on_i <= 1'b1;
        irq_is(1'b1);
        @(posedge clk_i);
        mcu_en <= 1'b1;
        for (int i = 0; i < 20 && irq_o !== 1'b0; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk({7'h00, irq_o}, 8'h00);
        if (irq_o !== 1'b0) tally_and_finish();
        @(posedge clk_i);
        mcu_en <= 1'b0;
        power_on_i <= 1'b0;
        irq_is(1'b0);
        @(posedge clk_i);
        n_power_on_i <= 1'b1;
        irq_is(1'b1);
        rd(`OFS_STATUS, 8'h01);
        irq_is(1'b0);
        @(posedge clk_i);
        n_power_on_i <= 1'b0;
        irq_is(1'b1);
        pulse(2);
        irq_is(1'b0);
        // ------------------------------
        // TX levels
        // ------------------------------
        wr(`OFS_CTRL, 8'h03);
        @(posedge clk_i);
        tx_active_i <= 1'b1;
        tx_fill_i <= 5'h0c;
        irq_is(1'b1);
        rd(`OFS_STATUS, 8'h04);
        irq_is(1'b1);
        pulse(3);
        irq_is(1'b0);
        @(posedge clk_i);
        tx_fill_i <= 5'h00;
        irq_is(1'b1);
        pulse(5);
        irq_is(1'b0);
        @(posedge clk_i);
        tx_fill_i <= 5'h01;
        irq_is(1'b0);
        // ------------------------------
        // RX levels for every threshold code
        // ------------------------------
        @(posedge clk_i);
        rx_active_i <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(`OFS_CTRL, 8'(s));
            @(posedge clk_i);
            rx_fill_i <= 5'h00;
            @(posedge clk_i);
            rx_fill_i <= thr[s];
            irq_is(1'b1);
            pulse(4);
            irq_is(1'b0);
        end
        // Reading suppresses count and error events
        wr(`OFS_CTRL, 8'h00);
        @(posedge clk_i);
        buf_reading_i <= 1'b1;
        rx_fill_i <= 5'h01;
        pulse(0);
        irq_is(1'b0);
        @(posedge clk_i);
        buf_reading_i <= 1'b0;
        pulse(0);
        irq_is(1'b1);
        wr(`OFS_CTRL, 8'h00);
        irq_is(1'b0);
        // ------------------------------
        // Bit-check and two-way mode
        // ------------------------------
        pulse(1);
        irq_is(1'b1);
        pulse(2);
        irq_is(1'b0);
        wr(`OFS_CTRL, 8'h08);
        pulse(1);
        irq_is(1'b0);
        wr(`OFS_CTRL, 8'h00);
        @(posedge clk_i);
        tx_active_i <= 1'b0;
        tx_fill_i <= 5'h05;
        two_way_simultaneous_mode_i <= 1'b1;
        irq_is(1'b0);
        @(posedge clk_i);
        tx_fill_i <= 5'h00;
        irq_is(1'b1);
        rd(`OFS_STATUS, 8'h40);
        pulse(4);
        irq_is(1'b0);
        // ------------------------------
        // Several pending sources and mask
        // ------------------------------
        pulse(1);
        @(posedge clk_i);
        n_power_on_i <= 1'b1;
        irq_is(1'b1);
        rd(`OFS_STATUS, 8'h21);
        irq_is(1'b1);
        wr(`OFS_MASK, 8'h1f);
        irq_is(1'b0);
        wr(`OFS_MASK, 8'h7f);
        irq_is(1'b1);
        wr(`OFS_STATUS, 8'h20);
        irq_is(1'b0);
        tally_and_finish();
    end
endmodule : tb_transceiver_irq_logic
